// ==== wtu_pkg.sv ====
// shared constants, fields and types of the wake and timekeeping unit
package wtu_pkg;
	// sub-second stage
	localparam int SS_W = 20;
	localparam logic [19:0] RELOAD_RST = 20'h7A120;
	localparam logic [2:0] XTAL_DIV_LAST = 3'h7;
	localparam logic [1:0] SRC_XTAL = 2'h0;
	localparam logic [1:0] SRC_RC = 2'h2;
	localparam logic [1:0] SRC_RST = 2'h0;
	localparam int OSC_SRC_LSB = 0;
	localparam int OSC_LD_BIT = 3;
	// time of day
	localparam logic [5:0] SEC_MAX = 6'h3B;
	localparam logic [5:0] MIN_MAX = 6'h3B;
	localparam logic [4:0] HR_MAX = 5'h17;
	localparam int TIME_SC_LSB = 0;
	localparam int TIME_MN_LSB = 8;
	localparam int TIME_HR_LSB = 16;
	localparam logic [4:0] TAP_COUNT = 5'h11;
	// register byte offsets
	localparam logic [7:0] OFF_OSC = 8'h00;
	localparam logic [7:0] OFF_RELOAD = 8'h04;
	localparam logic [7:0] OFF_SSCNT = 8'h08;
	localparam logic [7:0] OFF_TIME_SEC = 8'h0C;
	localparam logic [7:0] OFF_TIME_MH = 8'h10;
	localparam logic [7:0] OFF_TSEL = 8'h14;
	localparam logic [7:0] OFF_FLAGS = 8'h18;
	localparam logic [7:0] OFF_MODE0 = 8'h20;
	localparam logic [7:0] OFF_POLL = 8'h34;
	localparam logic [7:0] OFF_WSC = 8'h38;
	// field positions
	localparam int FLAG_RTC_BIT = 15;
	localparam int MODE_LO_LSB = 0;
	localparam int MODE_HI_LSB = 4;
	localparam int POLL_DEL_LSB = 0;
	localparam int POLL_OE_BIT = 6;
	localparam int POLL_ENA_BIT = 7;
	localparam int POLL_PER_LSB = 8;
	localparam int POLL_CLK_LSB = 16;
	localparam int WSC_AST_BIT = 0;
	localparam int WSC_RTC_BIT = 1;
	localparam int WSC_PORT_BIT = 2;
	localparam int WSC_CO_LSB = 4;
	// port trigger field codes
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_RISE = 3'h1;
	localparam logic [2:0] MODE_FALL = 3'h2;
	localparam logic [2:0] MODE_BOTH = 3'h3;
	localparam logic [2:0] MODE_HIGH = 3'h4;
	localparam logic [2:0] MODE_LOW = 3'h5;
	// clock output selection
	localparam logic [1:0] CO_LOW = 2'h0;
	localparam logic [1:0] CO_SECOND = 2'h1;
	localparam logic [1:0] CO_TAP = 2'h2;
	localparam logic [1:0] CO_POLL = 2'h3;

	typedef struct packed {
		logic [4:0] hr;
		logic [5:0] mn;
		logic [5:0] sc;
	} time_s;

	typedef struct packed {
		logic ena;
		logic oe;
		logic [4:0] per;
		logic [4:0] clk;
		logic [4:0] pulse_length_setting;
	} poll_cfg_s;

	typedef enum logic [1:0] {
		P_IDLE = 2'b01,
		P_HIGH = 2'b10
	} poll_state_e;
endpackage

// ==== mod_counter.sv ====
// modulo up counter with carry, one stage of the time-of-day chain
`timescale 1ns/1ps
module mod_counter #(
	parameter int W = 6,
	parameter logic [W-1:0] MAX = 6'h3B
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// count and load
	input wire logic tick_in,
	input wire logic load_in,
	input wire logic [W-1:0] load_val_in,
	// state
	output logic [W-1:0] count_out,
	output logic carry_out
);
	logic [W-1:0] count_q, count_d;

	// software load wins over a tick landing in the same cycle
	always_comb begin
		count_d = count_q;
		carry_out = 1'b0;
		if (load_in) begin
			count_d = load_val_in;
		end else if (tick_in) begin
			if (count_q >= MAX) begin
				count_d = '0;
				carry_out = 1'b1;
			end else begin
				count_d = count_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign count_out = count_q;

	property p_wrap;
		@(posedge clock_in) disable iff (sys_rst_in)
		carry_out |=> (count_q == '0);
	endproperty
	a_wrap: assert property (p_wrap) else $error("stage did not wrap to zero");

	property p_step;
		@(posedge clock_in) disable iff (sys_rst_in)
		(tick_in && !load_in && count_q < MAX) |=> (count_q == $past(count_q) + 1'b1);
	endproperty
	a_step: assert property (p_step) else $error("stage did not count up");
endmodule

// ==== wake_port_cell.sv ====
// trigger logic and sticky source flag of one wake port
`timescale 1ns/1ps
module wake_port_cell
	import wtu_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// configuration and stimulus
	input wire logic [2:0] mode_in,
	input wire logic pin_in,
	input wire logic strobe_in,
	input wire logic clear_in,
	// flag
	output logic flag_out
);
	logic prev_q, prev_d;
	logic hold_q, hold_d;
	logic flag_q, flag_d;
	logic cond;
	logic set;

	// pin is already synchronised by the caller
	always_comb begin
		prev_d = pin_in;
		cond = ((mode_in == MODE_HIGH) && pin_in) || ((mode_in == MODE_LOW) && !pin_in);
		hold_d = cond && (strobe_in || hold_q);
		set = 1'b0;
		case (mode_in)
			MODE_RISE: set = pin_in && !prev_q;
			MODE_FALL: set = !pin_in && prev_q;
			MODE_BOTH: set = pin_in != prev_q;
			MODE_HIGH, MODE_LOW: set = cond && (strobe_in || hold_q);
			default: set = 1'b0;
		endcase
		flag_d = set || (flag_q && !clear_in);
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			prev_q <= 1'b0;
			hold_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			hold_q <= hold_d;
			flag_q <= flag_d;
		end
	end

	assign flag_out = flag_q;

	property p_level_sample;
		@(posedge clock_in) disable iff (sys_rst_in)
		(strobe_in && mode_in == MODE_HIGH && pin_in) |=> flag_q;
	endproperty
	a_level_sample: assert property (p_level_sample) else $error("strobe missed level");

	property p_level_hold;
		@(posedge clock_in) disable iff (sys_rst_in)
		(hold_q && cond) |=> flag_q;
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("flag not held");

	property p_sticky;
		@(posedge clock_in) disable iff (sys_rst_in)
		(flag_q && !clear_in) |=> flag_q;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
endmodule

// ==== wake_timekeeping_unit.sv ====
// top of the always-on wake and timekeeping unit with its ahb-lite slave
// Summary of operation
// - unit runs in every operating mode
// - wake request only during low-power modes
// - 20-bit sub-second down counter reloads, clocks seconds
// - count clock is crystal/8 or rc oscillator
// - seconds clock minutes, minutes clock hours, upward
// - reading seconds latches minutes and hours
// - any time bit selects the time event
// - time counters ignore the debug clock halt
// - poll pulse starts on period tick rise
// - delay write loads counter; zero means 32
// - enable gates poll pulse onto its pin
// - pulse fall samples level-mode ports
// - poll period may stretch at reload
// - ten ports, own trigger and flag
// - two port trigger fields per register
// - alternate strobe replaces poll strobe for all
// - level flag held while condition lasts
// - port flags ored into one signal
// - selected internal clock driven to clock pin
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module wake_timekeeping_unit #(
	parameter int NPORT = 10
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// ahb-lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic hready_in,
	input wire logic [31:0] hwdata_in,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic [31:0] hrdata_out,
	// oscillator pins
	input wire logic xtal_clk_in,
	input wire logic rc_clk_in,
	// wake pins
	input wire logic [NPORT-1:0] wake_port_n_in,
	input wire logic alt_strobe_in,
	// system side
	input wire logic low_power_mode_in,
	output logic wake_request_out,
	output logic rtc_event_out,
	output logic port_event_out,
	output logic poll_out_out,
	output logic clock_out_pin_out
);
	import wtu_pkg::*;

	localparam int NS = NPORT + 3;
	localparam int NMODE = (NPORT + 1) / 2;

	logic [NS-1:0] meta_q, sync_q;
	logic [2:0] prev_q;
	logic xtal_rise, rc_rise, alt_fall;
	logic [NPORT-1:0] port_lvl, port_flag;

	// two flops on every pin; only the second is read
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= {alt_strobe_in, rc_clk_in, xtal_clk_in, wake_port_n_in};
			sync_q <= meta_q;
			prev_q <= sync_q[NS-1:NPORT];
		end
	end

	assign port_lvl = sync_q[NPORT-1:0];
	assign xtal_rise = sync_q[NPORT] && !prev_q[0];
	assign rc_rise = sync_q[NPORT+1] && !prev_q[1];
	assign alt_fall = !sync_q[NPORT+2] && prev_q[2];

	// bus address phase, registered for the write data phase
	logic ap_wr_q, ap_wr_d;
	logic [7:0] ap_addr_q, ap_addr_d;
	logic acc, rd;
	logic wr_osc, wr_reload, wr_time, wr_tsel, wr_flags, wr_poll, wr_wsc;
	logic [NMODE-1:0] wr_mode;
	logic ld_now;

	assign acc = hsel_in && htrans_in[1] && hready_in;
	assign rd = acc && !hwrite_in;
	assign wr_osc = ap_wr_q && ap_addr_q == OFF_OSC;
	assign wr_reload = ap_wr_q && ap_addr_q == OFF_RELOAD;
	assign wr_time = ap_wr_q && ap_addr_q == OFF_TIME_SEC;
	assign wr_tsel = ap_wr_q && ap_addr_q == OFF_TSEL;
	assign wr_flags = ap_wr_q && ap_addr_q == OFF_FLAGS;
	assign wr_poll = ap_wr_q && ap_addr_q == OFF_POLL;
	assign wr_wsc = ap_wr_q && ap_addr_q == OFF_WSC;
	assign ld_now = wr_osc && hwdata_in[OSC_LD_BIT];

	genvar gm;
	generate
		for (gm = 0; gm < NMODE; gm++) begin : g_mdec
			assign wr_mode[gm] = ap_wr_q && ap_addr_q == OFF_MODE0 + 8'(4 * gm);
		end
	endgenerate

	// sub-second stage; no halt input exists, so debug stop cannot reach it
	logic [1:0] src_q, src_d, src_req_q, src_req_d;
	logic [19:0] reload_q, reload_d, ss_q, ss_d;
	logic [2:0] div_q, div_d;
	logic half_q, half_d;
	logic ss_tick, ss_pulse;

	assign ss_tick = (src_q == SRC_XTAL) ? (xtal_rise && div_q == XTAL_DIV_LAST) :
		(src_q == SRC_RC) ? rc_rise : 1'b0;
	assign ss_pulse = ss_tick && ss_q <= 20'h00001 && !ld_now;

	// new source and reload take effect at the next reload unless forced
	always_comb begin
		src_d = src_q;
		src_req_d = src_req_q;
		reload_d = reload_q;
		ss_d = ss_q;
		half_d = half_q;
		div_d = xtal_rise ? div_q + 3'h1 : div_q;
		if (wr_osc) begin
			src_req_d = hwdata_in[OSC_SRC_LSB +: 2];
		end
		if (wr_reload) begin
			reload_d = hwdata_in[SS_W-1:0];
		end
		if (ld_now) begin
			src_d = hwdata_in[OSC_SRC_LSB +: 2];
			ss_d = reload_q;
		end else if (ss_pulse) begin
			ss_d = reload_q;
			src_d = src_req_q;
			half_d = !half_q;
		end else if (ss_tick) begin
			ss_d = ss_q - 20'h00001;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			src_q <= SRC_RST;
			src_req_q <= SRC_RST;
			reload_q <= RELOAD_RST;
			ss_q <= RELOAD_RST;
			div_q <= '0;
			half_q <= 1'b0;
		end else begin
			src_q <= src_d;
			src_req_q <= src_req_d;
			reload_q <= reload_d;
			ss_q <= ss_d;
			div_q <= div_d;
			half_q <= half_d;
		end
	end

	// time-of-day chain, counting while the source field selects the crystal or the rc oscillator
	time_s tm;
	logic sec_carry, min_carry;

	mod_counter #(.W(6), .MAX(SEC_MAX)) u_sec (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.tick_in(ss_pulse), .load_in(wr_time),
		.load_val_in(hwdata_in[TIME_SC_LSB +: 6]),
		.count_out(tm.sc), .carry_out(sec_carry)
	);
	mod_counter #(.W(6), .MAX(MIN_MAX)) u_min (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.tick_in(sec_carry), .load_in(wr_time),
		.load_val_in(hwdata_in[TIME_MN_LSB +: 6]),
		.count_out(tm.mn), .carry_out(min_carry)
	);
	mod_counter #(.W(5), .MAX(HR_MAX)) u_hr (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.tick_in(min_carry), .load_in(wr_time),
		.load_val_in(hwdata_in[TIME_HR_LSB +: 5]),
		.count_out(tm.hr), .carry_out()
	);

	// configuration, time event, latch and flags
	logic [4:0] tsel_q, tsel_d;
	poll_cfg_s poll_q, poll_d;
	logic ast_q, ast_d, rtc_en_q, rtc_en_d, port_en_q, port_en_d;
	logic [1:0] co_q, co_d;
	logic [NPORT-1:0][2:0] mode_q, mode_d;
	logic [10:0] latch_q, latch_d;
	logic tap, tap_prev_q, rtc_ev;
	logic rtc_flag_q, rtc_flag_d;

	assign tap = (tsel_q != 5'h00 && tsel_q <= TAP_COUNT) ? tm[tsel_q - 5'h01] : 1'b0;
	assign rtc_ev = tap && !tap_prev_q;

	always_comb begin
		tsel_d = wr_tsel ? hwdata_in[4:0] : tsel_q;
		poll_d = poll_q;
		ast_d = ast_q;
		rtc_en_d = rtc_en_q;
		port_en_d = port_en_q;
		co_d = co_q;
		mode_d = mode_q;
		latch_d = latch_q;
		if (rd && haddr_in[7:0] == OFF_TIME_SEC) begin
			latch_d = {tm.hr, tm.mn};
		end
		if (wr_poll) begin
			poll_d = {hwdata_in[POLL_ENA_BIT], hwdata_in[POLL_OE_BIT],
				hwdata_in[POLL_PER_LSB +: 5], hwdata_in[POLL_CLK_LSB +: 5],
				hwdata_in[POLL_DEL_LSB +: 5]};
		end
		if (wr_wsc) begin
			ast_d = hwdata_in[WSC_AST_BIT];
			rtc_en_d = hwdata_in[WSC_RTC_BIT];
			port_en_d = hwdata_in[WSC_PORT_BIT];
			co_d = hwdata_in[WSC_CO_LSB +: 2];
		end
		for (int k = 0; k < NPORT; k++) begin
			if (wr_mode[k/2]) begin
				mode_d[k] = (k % 2 == 0) ? hwdata_in[MODE_LO_LSB +: 3] :
					hwdata_in[MODE_HI_LSB +: 3];
			end
		end
		// a new event beats a clear in the same cycle
		rtc_flag_d = rtc_ev || (rtc_flag_q && !(wr_flags && hwdata_in[FLAG_RTC_BIT]));
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			tsel_q <= '0;
			poll_q <= '0;
			ast_q <= 1'b0;
			rtc_en_q <= 1'b0;
			port_en_q <= 1'b0;
			co_q <= CO_LOW;
			mode_q <= '0;
			latch_q <= '0;
			tap_prev_q <= 1'b0;
			rtc_flag_q <= 1'b0;
		end else begin
			tsel_q <= tsel_d;
			poll_q <= poll_d;
			ast_q <= ast_d;
			rtc_en_q <= rtc_en_d;
			port_en_q <= port_en_d;
			co_q <= co_d;
			mode_q <= mode_d;
			latch_q <= latch_d;
			tap_prev_q <= tap;
			rtc_flag_q <= rtc_flag_d;
		end
	end

	// polling pulse; period and length ticks are sub-second taps, hence
	// the period jitters around a reload
	poll_state_e state_q, state_d;
	logic [4:0] dcnt_q, dcnt_d;
	logic per_prev_q, clk_prev_q, per_rise, clk_rise, poll_end, strobe;

	assign per_rise = ss_q[poll_q.per] && !per_prev_q;
	assign clk_rise = ss_q[poll_q.clk] && !clk_prev_q;
	assign poll_end = state_q == P_HIGH && poll_q.ena && clk_rise && dcnt_q == 5'h01;
	assign strobe = ast_q ? alt_fall : poll_end;

	always_comb begin
		state_d = state_q;
		dcnt_d = dcnt_q;
		case (state_q)
			P_IDLE: begin
				if (poll_q.ena && per_rise) begin
					state_d = P_HIGH;
					dcnt_d = poll_q.pulse_length_setting;
				end
			end
			P_HIGH: begin
				if (!poll_q.ena || poll_end) begin
					state_d = P_IDLE;
				end else if (clk_rise) begin
					dcnt_d = dcnt_q - 5'h01;
				end
			end
			default: state_d = P_IDLE;
		endcase
		if (wr_poll) begin
			dcnt_d = hwdata_in[POLL_DEL_LSB +: 5];
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			state_q <= P_IDLE;
			dcnt_q <= '0;
			per_prev_q <= 1'b0;
			clk_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			dcnt_q <= dcnt_d;
			per_prev_q <= ss_q[poll_q.per];
			clk_prev_q <= ss_q[poll_q.clk];
		end
	end

	// wake ports
	genvar gp;
	generate
		for (gp = 0; gp < NPORT; gp++) begin : g_port
			wake_port_cell u_cell (
				.clock_in(clock_in), .sys_rst_in(sys_rst_in),
				.mode_in(mode_q[gp]), .pin_in(port_lvl[gp]),
				.strobe_in(strobe),
				.clear_in(wr_flags && hwdata_in[gp]),
				.flag_out(port_flag[gp])
			);
		end
	endgenerate

	// read mux and registered outputs; reads have no wait state
	logic [31:0] rdata;
	logic wake_q, wake_d, port_any_q, poll_pin_q, cout_q, cout_d;

	always_comb begin
		rdata = '0;
		case (haddr_in[7:0])
			OFF_OSC: rdata[OSC_SRC_LSB +: 2] = src_q;
			OFF_RELOAD: rdata[SS_W-1:0] = reload_q;
			OFF_SSCNT: rdata[SS_W-1:0] = ss_q;
			OFF_TIME_SEC: rdata[TIME_SC_LSB +: 6] = tm.sc;
			OFF_TIME_MH: rdata = {11'h000, latch_q[10:6], 2'h0, latch_q[5:0], 8'h00};
			OFF_TSEL: rdata[4:0] = tsel_q;
			OFF_FLAGS: rdata = {16'h0000, rtc_flag_q, 5'h00, port_flag};
			OFF_POLL: rdata = {11'h000, poll_q.clk, 3'h0, poll_q.per, poll_q.ena,
				poll_q.oe, 1'b0, poll_q.pulse_length_setting};
			OFF_WSC: rdata = {26'h0000000, co_q, 1'b0, port_en_q, rtc_en_q, ast_q};
			default: begin
				for (int m = 0; m < NMODE; m++) begin
					if (haddr_in[7:0] == OFF_MODE0 + 8'(4 * m)) begin
						rdata = {25'h0000000, mode_q[2*m+1], 1'b0, mode_q[2*m]};
					end
				end
			end
		endcase
		wake_d = low_power_mode_in && ((rtc_en_q && rtc_flag_q) ||
			(port_en_q && |port_flag));
		case (co_q)
			CO_SECOND: cout_d = half_q;
			CO_TAP: cout_d = tap;
			CO_POLL: cout_d = state_d == P_HIGH;
			default: cout_d = 1'b0;
		endcase
		ap_wr_d = acc && hwrite_in;
		ap_addr_d = haddr_in[7:0];
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			ap_wr_q <= 1'b0;
			ap_addr_q <= '0;
			hrdata_out <= '0;
			wake_q <= 1'b0;
			port_any_q <= 1'b0;
			poll_pin_q <= 1'b0;
			cout_q <= 1'b0;
		end else begin
			ap_wr_q <= ap_wr_d;
			ap_addr_q <= ap_addr_d;
			hrdata_out <= rd ? rdata : 32'h00000000;
			wake_q <= wake_d;
			port_any_q <= |port_flag;
			poll_pin_q <= poll_q.ena && poll_q.oe && state_d == P_HIGH;
			cout_q <= cout_d;
		end
	end

	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign wake_request_out = wake_q;
	assign rtc_event_out = rtc_flag_q;
	assign port_event_out = port_any_q;
	assign poll_out_out = poll_pin_q;
	assign clock_out_pin_out = cout_q;

	property p_wake_lp;
		@(posedge clock_in) disable iff (sys_rst_in)
		wake_request_out |-> $past(low_power_mode_in);
	endproperty
	a_wake_lp: assert property (p_wake_lp) else $error("wake outside low power");

	property p_reload;
		@(posedge clock_in) disable iff (sys_rst_in)
		ss_pulse |=> (ss_q == $past(reload_q));
	endproperty
	a_reload: assert property (p_reload) else $error("no reload on pulse");

	property p_latch;
		@(posedge clock_in) disable iff (sys_rst_in)
		(rd && haddr_in[7:0] == OFF_TIME_SEC) |=> (latch_q == $past({tm.hr, tm.mn}));
	endproperty
	a_latch: assert property (p_latch) else $error("time not latched");

	property p_rtc_ev;
		@(posedge clock_in) disable iff (sys_rst_in)
		rtc_ev |=> rtc_flag_q ##1 (rtc_event_out || $past(wr_flags));
	endproperty
	a_rtc_ev: assert property (p_rtc_ev) else $error("time event lost");

	sequence s_start;
		state_q == P_IDLE && poll_q.ena && per_rise && !wr_poll;
	endsequence
	sequence s_high;
		state_q == P_HIGH && dcnt_q == $past(poll_q.pulse_length_setting);
	endsequence
	property p_poll_start;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_start |=> s_high;
	endproperty
	a_poll_start: assert property (p_poll_start) else $error("poll pulse not started");

	property p_del_load;
		@(posedge clock_in) disable iff (sys_rst_in)
		wr_poll |=> (dcnt_q == $past(hwdata_in[4:0]));
	endproperty
	a_del_load: assert property (p_del_load) else $error("delay not loaded");

	property p_pin_gate;
		@(posedge clock_in) disable iff (sys_rst_in)
		poll_out_out |-> (state_q == P_HIGH && $past(poll_q.oe));
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("poll pin not gated");

	property p_or;
		@(posedge clock_in) disable iff (sys_rst_in)
		##1 (port_event_out == $past(|port_flag));
	endproperty
	a_or: assert property (p_or) else $error("port event not ored");
endmodule

// ==== wake_pin_model.sv ====
// behavioural model of the wake pins and the oscillator pins
`timescale 1ns/1ps
module wake_pin_model (
	// clock
	input wire logic clock_in,
	// commanded pin levels
	input wire logic [9:0] level_in,
	// pins
	output logic [9:0] wake_port_n_out,
	output logic rc_clk_out,
	output logic xtal_clk_out
);
	logic [1:0] div_q = 2'h0;
	logic rc_q = 1'b0;
	logic xtal_q = 1'b0;
	logic [9:0] pin_q = 10'h0;
	// one driver per pin, the registers below
	assign rc_clk_out = rc_q;
	assign xtal_clk_out = xtal_q;
	assign wake_port_n_out = pin_q;
	// rc pin far slower than the system clock so every edge survives the syncers
	always @(posedge clock_in) begin
		div_q <= div_q + 2'h1;
		if (div_q == 2'h3) begin
			rc_q <= ~rc_q;
		end
		xtal_q <= ~xtal_q; // crystal runs free
		pin_q <= level_in;
	end
endmodule

// ==== wake_timekeeping_unit_tb.sv ====
// self-checking bench of the wake and timekeeping unit
`timescale 1ns/1ps
module wake_timekeeping_unit_tb;
	import wtu_pkg::*;
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, wreq, rtc_ev, port_ev, poll_o, co_pin, rc_clk, xtal_clk;
	logic low_pwr = 1'b0;
	logic alt_stb = 1'b0;
	logic [9:0] lvl = 10'h0;
	logic [9:0] pins;
	logic [31:0] v;
	int n_fail = 0;
	int checks_done = 0;

	wake_pin_model wake_pin_model_i (.clock_in(clock_in), .level_in(lvl),
		.wake_port_n_out(pins), .rc_clk_out(rc_clk), .xtal_clk_out(xtal_clk));
	wake_timekeeping_unit wake_timekeeping_unit_i (.clock_in(clock_in),
		.sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hreadyout), .hwdata_in(hwdata),
		.hreadyout_out(hreadyout), .hresp_out(hresp), .hrdata_out(hrdata),
		.xtal_clk_in(xtal_clk), .rc_clk_in(rc_clk), .wake_port_n_in(pins),
		.alt_strobe_in(alt_stb), .low_power_mode_in(low_pwr), .wake_request_out(wreq),
		.rtc_event_out(rtc_ev), .port_event_out(port_ev), .poll_out_out(poll_o),
		.clock_out_pin_out(co_pin));

	initial begin
		forever #10 clock_in = ~clock_in;
	end

	// one single transfer, entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clock_in); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock_in); while (hreadyout !== 1'b1);
		v = hrdata;
	endtask
	// idle cycle after a write so a following read sees the new value
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		@(posedge clock_in);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(v, exp);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic t_reset;
		logic [31:0] v1;
		rdc(OFF_RELOAD, {12'h0, RELOAD_RST});
		rdc(OFF_OSC, 32'h0);
		rdc(OFF_TIME_SEC, 32'h0);
		rdc(8'h3C, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		// crystal pin toggles every cycle: one count per 16 cycles after the /8
		bus(1'b0, OFF_SSCNT, 32'h0);
		v1 = v;
		wait_cyc(158);
		bus(1'b0, OFF_SSCNT, 32'h0);
		chk(v1 - v, 32'hA);
		$display("reset test done");
	endtask
	// shortened second keeps the run short; software owns the reload choice
	task automatic t_rtc;
		wr(OFF_RELOAD, 32'h20);
		wr(OFF_OSC, 32'hA);
		rdc(OFF_OSC, {30'h0, SRC_RC});
		bus(1'b0, OFF_SSCNT, 32'h0);
		chk({31'h0, v <= 32'h20 && v != 32'h0}, 32'h1);
		wr(OFF_TSEL, 32'h1);
		wr(OFF_WSC, 32'h2);
		for (int i = 0; i < 700 && rtc_ev !== 1'b1; i++) @(posedge clock_in);
		chk({31'h0, rtc_ev}, 32'h1);
		chk({31'h0, wreq}, 32'h0);
		low_pwr <= 1'b1;
		wait_cyc(3);
		chk({31'h0, wreq}, 32'h1);
		low_pwr <= 1'b0;
		wr(OFF_TSEL, 32'h0);
		wr(OFF_FLAGS, 32'h8000);
		wait_cyc(2);
		chk({31'h0, rtc_ev}, 32'h0);
		$display("time event test done");
	endtask
	// counting halted so the latched read cannot straddle a second
	task automatic t_time;
		wr(OFF_OSC, 32'hB);
		wr(OFF_TIME_SEC, 32'h00173B3B);
		rdc(OFF_TIME_SEC, 32'h3B);
		rdc(OFF_TIME_MH, 32'h00173B00);
		wr(OFF_OSC, 32'hA);
		v = 32'h1;
		for (int i = 0; i < 200 && v[5:0] != 6'h0; i++) bus(1'b0, OFF_TIME_SEC, 32'h0);
		chk(v, 32'h0);
		rdc(OFF_TIME_MH, 32'h0);
		$display("time wrap test done");
	endtask
	// port 0 rising, port 1 falling, port 4 both edges
	task automatic t_edge;
		wr(OFF_MODE0, {25'h0, MODE_FALL, 1'b0, MODE_RISE});
		wr(OFF_MODE0 + 8'h8, {29'h0, MODE_BOTH});
		lvl[1:0] <= 2'h3;
		wait_cyc(8);
		rdc(OFF_FLAGS, 32'h1);
		chk({31'h0, port_ev}, 32'h1);
		wr(OFF_FLAGS, 32'h0);
		rdc(OFF_FLAGS, 32'h1);
		wr(OFF_FLAGS, 32'h1);
		rdc(OFF_FLAGS, 32'h0);
		lvl[4:1] <= 4'h8;
		wait_cyc(8);
		rdc(OFF_FLAGS, 32'h12);
		wr(OFF_FLAGS, 32'h12);
		lvl[4] <= 1'b0;
		wait_cyc(8);
		rdc(OFF_FLAGS, 32'h10);
		wr(OFF_FLAGS, 32'h10);
		$display("edge port test done");
	endtask
	// port 2 high level, port 3 low level, strobed by the alternate pin
	task automatic t_level;
		wr(OFF_WSC, 32'h1);
		wr(OFF_MODE0 + 8'h4, 32'h54);
		lvl[2] <= 1'b1;
		wait_cyc(4);
		alt_stb <= 1'b1;
		wait_cyc(5);
		alt_stb <= 1'b0;
		wait_cyc(6);
		rdc(OFF_FLAGS, 32'hC);
		wr(OFF_FLAGS, 32'hC);
		rdc(OFF_FLAGS, 32'hC);
		lvl[3:2] <= 2'h2;
		wait_cyc(6);
		wr(OFF_FLAGS, 32'hC);
		rdc(OFF_FLAGS, 32'h0);
		$display("level port test done");
	endtask
	// period tap 3 against delay 1 of tap 0 keeps period at eight delays
	task automatic t_poll;
		wr(OFF_WSC, 32'h0);
		lvl[2] <= 1'b1;
		wr(OFF_POLL, 32'h3C1);
		for (int i = 0; i < 600 && poll_o !== 1'b1; i++) @(posedge clock_in);
		chk({31'h0, poll_o}, 32'h1);
		for (int i = 0; i < 400 && poll_o !== 1'b0; i++) @(posedge clock_in);
		chk({31'h0, poll_o}, 32'h0);
		wait_cyc(6);
		rdc(OFF_FLAGS, 32'h4);
		wr(OFF_POLL, 32'h381);
		for (int i = 0; i < 400 && poll_o !== 1'b1; i++) @(posedge clock_in);
		chk({31'h0, poll_o}, 32'h0);
		$display("poll test done");
	endtask
	// second square, seconds bit 0 tap, then the poll pulse still running
	task automatic t_clkout;
		logic s;
		wr(OFF_TSEL, 32'h1);
		for (int c = 1; c < 4; c++) begin
			wr(OFF_WSC, c << WSC_CO_LSB);
			wait_cyc(2);
			s = co_pin;
			for (int i = 0; i < 700 && co_pin === s; i++) @(posedge clock_in);
			chk({31'h0, co_pin}, {31'h0, ~s});
		end
		$display("clock out test done");
	endtask

	initial begin
		wait_cyc(8);
		sys_rst_in <= 1'b0;
		@(posedge clock_in);
		t_reset();
		t_rtc();
		t_time();
		t_edge();
		t_level();
		t_poll();
		t_clkout();
		final_report();
	end
	// watchdog well above the few thousand cycles the tests need
	initial begin
		#400000;
		n_fail++;
		final_report();
	end
endmodule
